// file: logic/csp_pkg.sv
// Constants shared by the charger status pin logic
package csp_pkg;
   localparam int unsigned CLK_HZ        = 40_000_000;   // Core clock rate
   localparam int unsigned PULSE_NS      = 128_000;      // Fault pulse, 128 us
   localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
   localparam int unsigned PULSE_CYC     = PULSE_NS / CLK_NS;  // 5120 cycles
   localparam int unsigned TH_LEVELS     = 4;            // Thermistor thresholds
   localparam int unsigned TH_CODE_W     = 3;            // Zone code width
   // Thermistor zone codes, ordered from hot to cold
   localparam logic [2:0]  ZONE_HOT      = 3'h0;
   localparam logic [2:0]  ZONE_WARM     = 3'h1;
   localparam logic [2:0]  ZONE_NORMAL   = 3'h2;
   localparam logic [2:0]  ZONE_COOL     = 3'h3;
   localparam logic [2:0]  ZONE_COLD     = 3'h4;
   typedef enum logic [1:0] {
      CSP_IDLE  = 2'b01,
      CSP_PULSE = 2'b10
   } csp_state_e;
endpackage

// file: logic/csp_status_pins.sv
// Status, shutdown and gate-drive pin logic of the charger
`timescale 1ns/1ps
`default_nettype none
module csp_status_pins #(
   parameter int unsigned PULSE_CYC = csp_pkg::PULSE_CYC,   // Fault pulse length in cycles
   parameter int unsigned TH_W      = 8                      // Thermistor reading width
) (
   input  wire logic            core_clk,          // 40 MHz core clock
   input  wire logic            resetn,            // Async reset, active low
   input  wire logic            hw_shutdown_input, // High: high-impedance mode
   input  wire logic            charging,          // Charge cycle in progress
   input  wire logic            fault_event,       // One-cycle fault strobe
   input  wire logic            en_stat,           // Status output enable bit
   input  wire logic            supplement_mode,   // Battery supplementing system
   input  wire logic            input_present,     // Input supply connected
   input  wire logic [TH_W-1:0] battery_thermistor_input, // Digitised thermistor level
   input  wire logic [TH_W-1:0] th_hot,            // Threshold, hot limit
   input  wire logic [TH_W-1:0] th_warm,           // Threshold, warm limit
   input  wire logic [TH_W-1:0] th_cool,           // Threshold, cool limit
   input  wire logic [TH_W-1:0] th_cold,           // Threshold, cold limit
   output logic                 stat_out,          // Progress pin output value, always 0
   output logic                 stat_oe,           // Progress pin driven low when high
   output logic                 int_out,           // Alert pin output value, always 0
   output logic                 int_oe,            // Alert pin driven low when high
   output logic                 discharge_gate_drive, // Gate drive level
   output logic                 hiz_mode,          // Device in high-impedance mode
   output logic [2:0]           th_zone,           // Thermistor zone for host status
   output logic                 th_fault           // Zone outside normal band
);

   ////////////////////////////////////////////////////////////////////////
   // Fault pulse timer

   // Counter width follows the pulse length, so long pulses never wrap early
   localparam int unsigned CNT_W = (PULSE_CYC > 1) ? $clog2(PULSE_CYC) : 1;

   csp_pkg::csp_state_e state, next_state;
   logic [CNT_W-1:0]    cnt, next_cnt;
   logic                pulse;

   // Load on a fault, count down to zero, then drop back to idle.
   // A fault inside the pulse reloads the count, so a burst stretches it
   // rather than stacking several pulses the host could not tell apart.
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      unique case (state)
         csp_pkg::CSP_IDLE: begin
            if (fault_event && !hw_shutdown_input) begin
               next_state = csp_pkg::CSP_PULSE;
               next_cnt   = CNT_W'(PULSE_CYC - 1);
            end
         end
         csp_pkg::CSP_PULSE: begin
            if (fault_event) begin
               next_cnt = CNT_W'(PULSE_CYC - 1);  // New fault restarts the pulse
            end else if (cnt == '0) begin
               next_state = csp_pkg::CSP_IDLE;
            end else begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
         default: begin
            next_state = csp_pkg::CSP_IDLE;       // Illegal one-hot code recovers
            next_cnt   = '0;
         end
      endcase
   end

   // Timer registers; reset leaves no pulse pending
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= csp_pkg::CSP_IDLE;
         cnt   <= '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   assign pulse = (state == csp_pkg::CSP_PULSE);

   ////////////////////////////////////////////////////////////////////////
   // Pin levels

   // Open-drain pull decision shared by both status pins; a pulse inverts
   // the steady level, so the host sees an edge whatever the charge state
   function automatic logic pull_low(input logic enable,
                                     input logic shutdown,
                                     input logic chg,
                                     input logic pls);
      return enable && !shutdown && (chg ^ pls);
   endfunction

   logic                          next_stat_oe;
   logic                          next_int_oe;
   logic                          next_dgate;
   logic                          next_th_fault;
   logic [csp_pkg::TH_CODE_W-1:0] next_zone;

   // Next pin levels, gate drive and thermistor band
   always_comb begin
      next_stat_oe  = pull_low(en_stat, hw_shutdown_input, charging, pulse);
      next_int_oe   = pull_low(en_stat, hw_shutdown_input, charging, pulse);
      next_dgate    = !(supplement_mode || !input_present);
      // Hot side tested first; a reading on a threshold counts in the band further from normal
      if (battery_thermistor_input <= th_hot)       next_zone = csp_pkg::ZONE_HOT;
      else if (battery_thermistor_input <= th_warm) next_zone = csp_pkg::ZONE_WARM;
      else if (battery_thermistor_input <  th_cool) next_zone = csp_pkg::ZONE_NORMAL;
      else if (battery_thermistor_input <  th_cold) next_zone = csp_pkg::ZONE_COOL;
      else                                          next_zone = csp_pkg::ZONE_COLD;
      next_th_fault = (next_zone != csp_pkg::ZONE_NORMAL);
   end

   // Registered pins; reset releases both status pins and parks the gate low
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stat_oe              <= 1'b0;
         int_oe               <= 1'b0;
         discharge_gate_drive <= 1'b0;
         hiz_mode             <= 1'b0;
         th_zone              <= csp_pkg::ZONE_NORMAL;
         th_fault             <= 1'b0;
      end else begin
         stat_oe              <= next_stat_oe;
         int_oe               <= next_int_oe;
         discharge_gate_drive <= next_dgate;
         hiz_mode             <= hw_shutdown_input;
         th_zone              <= next_zone;
         th_fault             <= next_th_fault;
      end
   end

   // Open-drain pins only ever drive low; the enables carry the level
   assign stat_out = 1'b0;
   assign int_out  = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // Start condition: a fault seen while idle and not shut down
   sequence s_fault_start;
      fault_event && !hw_shutdown_input && state == csp_pkg::CSP_IDLE;
   endsequence

   // Timer freshly loaded with the full pulse length
   sequence s_pulse_loaded;
      pulse && cnt == CNT_W'(PULSE_CYC - 1);
   endsequence

   // Timer running with no new fault arriving
   sequence s_pulse_running;
      pulse && !fault_event;
   endsequence

   // Timer: start, reload, count down and finish on time
   a_pulse_starts: assert property (@(posedge core_clk) disable iff (!resetn)
      s_fault_start |=> pulse)
      else $error("pulse did not start");
   a_pulse_load: assert property (@(posedge core_clk) disable iff (!resetn)
      s_fault_start |=> s_pulse_loaded)
      else $error("pulse not loaded");
   a_pulse_restart: assert property (@(posedge core_clk) disable iff (!resetn)
      (pulse && fault_event) |=> s_pulse_loaded)
      else $error("pulse not restarted");
   a_shutdown_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
      (fault_event && hw_shutdown_input && state == csp_pkg::CSP_IDLE) |=> !pulse)
      else $error("fault taken in shutdown");
   a_count_down: assert property (@(posedge core_clk) disable iff (!resetn)
      s_pulse_running ##0 (cnt != '0) |=> (pulse && cnt == $past(cnt) - CNT_W'(1)))
      else $error("counter stalled");
   a_pulse_ends: assert property (@(posedge core_clk) disable iff (!resetn)
      s_pulse_running ##0 (cnt == '0) |=> !pulse)
      else $error("pulse overran");

   // Status pins: enable, charge level, pulse inversion and alert copy
   a_disabled_off: assert property (@(posedge core_clk) disable iff (!resetn)
      (!en_stat || hw_shutdown_input) |=> (!stat_oe && !int_oe))
      else $error("driven while off");
   a_charge_low: assert property (@(posedge core_clk) disable iff (!resetn)
      (en_stat && !hw_shutdown_input && charging && !pulse) |=> stat_oe)
      else $error("not low in charge");
   a_done_released: assert property (@(posedge core_clk) disable iff (!resetn)
      (!charging && !pulse) |=> !stat_oe)
      else $error("not released");
   a_alert_low: assert property (@(posedge core_clk) disable iff (!resetn)
      (en_stat && !hw_shutdown_input && charging && !pulse) |=> int_oe)
      else $error("alert not low in charge");
   a_alert_released: assert property (@(posedge core_clk) disable iff (!resetn)
      (!charging && !pulse) |=> !int_oe)
      else $error("alert not released");
   a_alert_mirrors: assert property (@(posedge core_clk) disable iff (!resetn)
      int_oe == stat_oe)
      else $error("alert differs");
   a_pulse_flips: assert property (@(posedge core_clk) disable iff (!resetn)
      (en_stat && !hw_shutdown_input && pulse) |=> (stat_oe == !$past(charging)))
      else $error("pulse not seen");

   // Gate drive and shutdown flag follow their inputs one edge later
   a_gate_low: assert property (@(posedge core_clk) disable iff (!resetn)
      (supplement_mode || !input_present) |=> !discharge_gate_drive)
      else $error("gate high");
   a_gate_high: assert property (@(posedge core_clk) disable iff (!resetn)
      (!supplement_mode && input_present) |=> discharge_gate_drive)
      else $error("gate low");
   a_hiz_follows: assert property (@(posedge core_clk) disable iff (!resetn)
      1'b1 |=> (hiz_mode == $past(hw_shutdown_input)))
      else $error("shutdown flag lags");

   // Thermistor bands, checked hot side first as the decoder does
   a_hot_zone: assert property (@(posedge core_clk) disable iff (!resetn)
      (battery_thermistor_input <= th_hot) |=> th_zone == csp_pkg::ZONE_HOT)
      else $error("zone wrong");
   a_warm_zone: assert property (@(posedge core_clk) disable iff (!resetn)
      (battery_thermistor_input > th_hot && battery_thermistor_input <= th_warm)
         |=> th_zone == csp_pkg::ZONE_WARM)
      else $error("warm zone wrong");
   a_normal_zone: assert property (@(posedge core_clk) disable iff (!resetn)
      (battery_thermistor_input > th_hot && battery_thermistor_input > th_warm &&
       battery_thermistor_input < th_cool)
         |=> (th_zone == csp_pkg::ZONE_NORMAL && !th_fault))
      else $error("normal zone wrong");
   a_cool_zone: assert property (@(posedge core_clk) disable iff (!resetn)
      (battery_thermistor_input > th_hot && battery_thermistor_input > th_warm &&
       battery_thermistor_input >= th_cool && battery_thermistor_input < th_cold)
         |=> (th_zone == csp_pkg::ZONE_COOL && th_fault))
      else $error("cool zone wrong");
   a_cold_zone: assert property (@(posedge core_clk) disable iff (!resetn)
      (battery_thermistor_input > th_hot && battery_thermistor_input > th_warm &&
       battery_thermistor_input >= th_cool && battery_thermistor_input >= th_cold)
         |=> (th_zone == csp_pkg::ZONE_COLD && th_fault))
      else $error("cold zone wrong");
   a_fault_flag: assert property (@(posedge core_clk) disable iff (!resetn)
      th_fault == (th_zone != csp_pkg::ZONE_NORMAL))
      else $error("fault flag wrong");
endmodule
`default_nettype wire

// file: tb/csp_host_model.sv
// Host side of the open-drain status pins, with board pull-ups
`timescale 1ns/1ps
`default_nettype none
module csp_host_model (
   input  wire logic stat_out, // Progress pin data
   input  wire logic stat_oe,  // Progress pin enable
   input  wire logic int_out,  // Alert pin data
   input  wire logic int_oe,   // Alert pin enable
   output logic      stat_pin, // Resolved progress wire
   output logic      int_pin   // Resolved alert wire
);
   // Released pins float up to the pull-up level
   assign stat_pin = stat_oe ? stat_out : 1'b1;
   assign int_pin  = int_oe ? int_out : 1'b1;
endmodule
`default_nettype wire

// file: tb/tb_charger_status_pin_logic.sv
// Self-checking bench for the charger status pin logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) samples_checked++; if ((a) !== (b)) begin errors++; $display("Error t=%0t got %h exp %h", $time, a, b); end
module tb_charger_status_pin_logic;
   logic       core_clk = 0, resetn = 0, hw_shutdown_input = 0, charging = 0, fault_event = 0, en_stat = 0;
   logic       supplement_mode = 0, input_present = 0, chk = 0;
   logic [7:0] battery_thermistor_input = 8'h00, th_hot = 8'h28, th_warm = 8'h50, th_cool = 8'hA0, th_cold = 8'hC8;
   logic       stat_out, stat_oe, int_out, int_oe, discharge_gate_drive, hiz_mode, th_fault, stat_pin, int_pin;
   logic [2:0] th_zone;
   logic [7:0] exp_q[$];
   int         errors = 0, samples_checked = 0, tests = 0;
   always #12.5 core_clk = ~core_clk;
   csp_status_pins #(.PULSE_CYC(8), .TH_W(8)) dut (.core_clk(core_clk), .resetn(resetn),
      .hw_shutdown_input(hw_shutdown_input), .charging(charging), .fault_event(fault_event), .en_stat(en_stat),
      .supplement_mode(supplement_mode), .input_present(input_present),
      .battery_thermistor_input(battery_thermistor_input), .th_hot(th_hot), .th_warm(th_warm), .th_cool(th_cool),
      .th_cold(th_cold), .stat_out(stat_out), .stat_oe(stat_oe), .int_out(int_out), .int_oe(int_oe),
      .discharge_gate_drive(discharge_gate_drive), .hiz_mode(hiz_mode), .th_zone(th_zone), .th_fault(th_fault));
   csp_host_model host (.stat_out(stat_out), .stat_oe(stat_oe), .int_out(int_out), .int_oe(int_oe),
      .stat_pin(stat_pin), .int_pin(int_pin));
   // Zone bands worked out independently of the design
   function automatic logic [2:0] zone(input logic [7:0] t);
      if (t <= th_hot) return csp_pkg::ZONE_HOT;
      if (t <= th_warm) return csp_pkg::ZONE_WARM;
      if (t < th_cool) return csp_pkg::ZONE_NORMAL;
      if (t < th_cold) return csp_pkg::ZONE_COOL;
      return csp_pkg::ZONE_COLD;
   endfunction
   // Host drives pins, optional fault strobe, then notes the expectation
   task automatic go(input logic s, input logic c, input logic e, input logic f, input int n, input logic p);
      logic pin;
      @(posedge core_clk);
      hw_shutdown_input <= s;
      charging <= c;
      en_stat <= e;
      fault_event <= f;
      supplement_mode <= 1'($urandom);
      input_present <= 1'($urandom);
      battery_thermistor_input <= 8'($urandom);
      @(posedge core_clk);
      fault_event <= 1'b0;
      repeat (n) @(posedge core_clk);
      pin = ~(e & ~s & (c ^ p));
      exp_q.push_back({pin, pin, ~supplement_mode & input_present, s, zone(battery_thermistor_input),
         zone(battery_thermistor_input) != csp_pkg::ZONE_NORMAL});
      chk <= 1'b1;
      @(posedge core_clk);
      chk <= 1'b0;
   endtask
   // Watcher takes the oldest note whenever a result is due
   always @(negedge core_clk) begin
      if (chk && exp_q.size() > 0) begin
         `CHK({stat_pin, int_pin, discharge_gate_drive, hiz_mode, th_zone, th_fault}, exp_q.pop_front())
         tests++;
         $display("test %0d done", tests);
      end
   end
   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      #100000;
      errors++;
      summarize();
   end
   initial begin
      void'($urandom(96));
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      go(0, 1, 1, 0, 3, 0);  // Charging pulls both pins low
      go(0, 0, 1, 0, 3, 0);  // Done releases
      go(0, 1, 0, 0, 3, 0);  // Enable bit off releases
      go(1, 1, 1, 0, 3, 0);  // Shutdown releases
      go(1, 0, 1, 1, 1, 0);  // Fault while shut down is ignored
      go(0, 0, 1, 0, 3, 0);  // No stale pulse afterwards
      go(0, 0, 1, 1, 3, 1);  // Idle fault pulls low
      go(0, 0, 1, 0, 20, 0); // Pulse ended, released again
      go(0, 1, 1, 1, 3, 1);  // Charging fault releases mid-pulse
      go(0, 1, 1, 0, 20, 0); // Returns to charging level
      // Random ascending thresholds, thermistor, gate, charge and enable inputs
      for (int i = 0; i < 8; i++) begin
         th_hot <= 8'($urandom_range(8'h3F, 8'h00));
         th_warm <= 8'($urandom_range(8'h7F, 8'h40));
         th_cool <= 8'($urandom_range(8'hBF, 8'h80));
         th_cold <= 8'($urandom_range(8'hFF, 8'hC0));
         go(0, 1'($urandom), 1'($urandom), 0, 3, 0);
      end
      go(0, 0, 1, 1, 3, 1); // Idle fault pulls low
      go(0, 0, 1, 1, 3, 1); // Fault late in the pulse restarts it
      resetn <= 1'b0;       // Reset in mid-pulse clears pins and timer
      @(posedge core_clk);
      exp_q.push_back({1'b1, 1'b1, 1'b0, 1'b0, csp_pkg::ZONE_NORMAL, 1'b0});
      chk <= 1'b1;
      @(posedge core_clk);
      chk <= 1'b0;
      resetn <= 1'b1;
      go(0, 0, 1, 0, 3, 0); // No pulse survives reset
      summarize();
   end
endmodule
`default_nettype wire
